/* File: gpio_pkg.sv */
// package: register map, field layout and carriers for the third port block
package gpio_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] data_off = 12'h000;
  localparam logic [11:0] direction_off = 12'h004;
  localparam logic [11:0] latch_off = 12'h008;
  localparam logic [11:0] open_drain_off = 12'h00C;
  localparam logic [11:0] periph_ctrl_off = 12'h010;

  // reset values
  localparam logic [7:0] direction_reset = 8'hFF;
  localparam logic [7:0] latch_reset = 8'h00;
  localparam logic [3:0] open_drain_reset = 4'h0;
  localparam logic [1:0] periph_ctrl_reset = 2'h0;
  localparam logic [31:0] unmapped_read = 32'h00000000;

  // open-drain control field positions
  localparam int od_unit_one = 0;
  localparam int od_unit_two = 1;
  localparam int od_sync_serial = 2;
  localparam int od_async_serial = 3;

  // peripheral control field positions
  localparam int pc_osc_enable = 0;
  localparam int pc_pwm_release = 1;

  // pin positions
  localparam int pin_zero = 0;
  localparam int pin_one = 1;
  localparam int pin_two = 2;
  localparam int pin_sck = 3;
  localparam int pin_sdo = 5;
  localparam int pin_tx = 6;

  // one peripheral's claim on a pin
  typedef struct packed {
    logic active;
    logic force_out;
    logic data;
  } periph_drive_type;

  // pad-side carrier for the eight pins
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] out_en_n;
  } pad_drive_type;

endpackage

/* File: pin_sync.sv */
// two-stage synchroniser for one schmitt-buffered port pin
`timescale 1ns/1ns
module pin_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin in, sampled level out
  input wire logic pin_in,
  output logic level
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  always_comb begin
    next_state.meta = pin_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.stable;

endmodule // pin_sync

/* File: third_port.sv */
// eight-pin general purpose port with peripheral overrides and apb registers
//
// Contract
// - eight bidirectional pins, each with its own direction bit and latch bit
// - pins two to seven are purely digital, no analogue function
// - each pin input is schmitt-sampled; data register reads the sampled level
// - open-drain bit makes peripheral-driven pin drive low only, float high
// - pin select bit chooses second compare unit mapping; 1 puts it on pin one
// - an active serial peripheral forces pin output or input regardless of direction bit; compare units drive only at direction 0
// - any device reset makes every pin a digital input; an active serial unit still sets the direction of its own pins
// - direction register reads stored bits, never the effective direction
// - direction 1 means input, 0 means output; 0xCF makes pins four, five outputs
// - pin zero clocks secondary timer only while secondary oscillator disabled
// - direction 0: compare output beats latch; direction 1: pin feeds capture
// - pwm channel a output beats port data; shutdown may release it to float
// - secondary oscillator input on pin one makes it analogue, direction ignored
`timescale 1ns/1ns
module third_port (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap sampled after reset release
  input wire logic second_compare_pin_select,
  // pads
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic pin_one_analog,
  // compare units: output claims and pwm shutdown
  input wire gpio_pkg::periph_drive_type enhanced_compare_unit_one,
  input wire gpio_pkg::periph_drive_type enhanced_compare_unit_two,
  input wire logic pwm_shutdown_one,
  input wire logic pwm_shutdown_two,
  output logic unit_one_capture,
  output logic unit_two_capture,
  // serial units
  input wire gpio_pkg::periph_drive_type sync_serial_clock,
  input wire gpio_pkg::periph_drive_type sync_serial_data,
  input wire gpio_pkg::periph_drive_type async_serial_unit,
  // secondary oscillator and timer clock
  output logic secondary_osc_enabled,
  output logic secondary_clock_input
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] third_port_direction;
    logic [7:0] third_port_output_latch;
    logic [3:0] open_drain_control;
    logic [1:0] periph_ctrl;
    logic strap_taken;
    logic compare_pin_sel;
    logic [31:0] rdata;
  } port_state_type;

  port_state_type state;
  port_state_type next_state;

  logic [7:0] pin_level;
  logic wr_en;
  logic rd_en;
  logic unit_two_on_pin_one;
  gpio_pkg::pad_drive_type pad;

  // ------------------------------------------------------------
  // input sampling
  // ------------------------------------------------------------
  // schmitt buffer is in the pad; here both flops keep metastability out
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_sync
      pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pin_in[g]),
        .level(pin_level[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  // zero-wait slave: access phase always completes in one cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    next_state = state;
    // strap caught once, one clock after reset release
    if (!state.strap_taken) begin
      next_state.strap_taken = 1'b1;
      next_state.compare_pin_sel = second_compare_pin_select;
    end
    if (wr_en) begin
      case (paddr)
        gpio_pkg::data_off: begin
          next_state.third_port_output_latch = pwdata[7:0];
        end
        gpio_pkg::latch_off: begin
          next_state.third_port_output_latch = pwdata[7:0];
        end
        gpio_pkg::direction_off: begin
          next_state.third_port_direction = pwdata[7:0];
        end
        gpio_pkg::open_drain_off: begin
          next_state.open_drain_control = pwdata[3:0];
        end
        gpio_pkg::periph_ctrl_off: begin
          next_state.periph_ctrl = pwdata[1:0];
        end
        default: begin
          next_state.periph_ctrl = state.periph_ctrl;
        end
      endcase
    end
    // read data captured in setup so it is stable through the access phase
    if (rd_en) begin
      case (paddr)
        gpio_pkg::data_off: next_state.rdata = {24'h000000, pin_level};
        gpio_pkg::direction_off: begin
          next_state.rdata = {24'h000000, state.third_port_direction};
        end
        gpio_pkg::latch_off: begin
          next_state.rdata = {24'h000000, state.third_port_output_latch};
        end
        gpio_pkg::open_drain_off: next_state.rdata = {28'h0000000, state.open_drain_control};
        gpio_pkg::periph_ctrl_off: next_state.rdata = {30'h00000000, state.periph_ctrl};
        default: next_state.rdata = gpio_pkg::unmapped_read;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.third_port_direction <= gpio_pkg::direction_reset;
      state.third_port_output_latch <= gpio_pkg::latch_reset;
      state.open_drain_control <= gpio_pkg::open_drain_reset;
      state.periph_ctrl <= gpio_pkg::periph_ctrl_reset;
      state.strap_taken <= 1'b0;
      state.compare_pin_sel <= 1'b1;
      state.rdata <= gpio_pkg::unmapped_read;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.rdata;
  assign pslverr = 1'b0;

  // ------------------------------------------------------------
  // pin mux
  // ------------------------------------------------------------
  assign secondary_osc_enabled = state.periph_ctrl[gpio_pkg::pc_osc_enable];
  assign unit_two_on_pin_one = state.compare_pin_sel;
  assign pin_one_analog = secondary_osc_enabled;

  // plain port, then peripheral overrides by pin
  always_comb begin
    pad.out = state.third_port_output_latch;
    pad.out_en_n = state.third_port_direction;
    // pin zero: oscillator owns it when running
    if (secondary_osc_enabled) begin
      pad.out_en_n[gpio_pkg::pin_zero] = 1'b1;
    end
    // pin one: oscillator wins over everything, direction ignored
    if (secondary_osc_enabled) begin
      pad.out_en_n[gpio_pkg::pin_one] = 1'b1;
    end else if (unit_two_on_pin_one && enhanced_compare_unit_two.active
                 && !state.third_port_direction[gpio_pkg::pin_one]) begin
      pad.out[gpio_pkg::pin_one] = enhanced_compare_unit_two.data;
      pad.out_en_n[gpio_pkg::pin_one] =
        (pwm_shutdown_two && state.periph_ctrl[gpio_pkg::pc_pwm_release]) ||
        (state.open_drain_control[gpio_pkg::od_unit_two]
         && enhanced_compare_unit_two.data);
    end
    // pin two: first compare unit
    if (enhanced_compare_unit_one.active
        && !state.third_port_direction[gpio_pkg::pin_two]) begin
      pad.out[gpio_pkg::pin_two] = enhanced_compare_unit_one.data;
      pad.out_en_n[gpio_pkg::pin_two] =
        (pwm_shutdown_one && state.periph_ctrl[gpio_pkg::pc_pwm_release]) ||
        (state.open_drain_control[gpio_pkg::od_unit_one]
         && enhanced_compare_unit_one.data);
    end
    // serial clock and data: peripheral sets direction itself
    if (sync_serial_clock.active) begin
      pad.out[gpio_pkg::pin_sck] = sync_serial_clock.data;
      pad.out_en_n[gpio_pkg::pin_sck] = !sync_serial_clock.force_out ||
        (state.open_drain_control[gpio_pkg::od_sync_serial]
         && sync_serial_clock.data);
    end
    if (sync_serial_data.active) begin
      pad.out[gpio_pkg::pin_sdo] = sync_serial_data.data;
      pad.out_en_n[gpio_pkg::pin_sdo] = !sync_serial_data.force_out ||
        (state.open_drain_control[gpio_pkg::od_sync_serial]
         && sync_serial_data.data);
    end
    if (async_serial_unit.active) begin
      pad.out[gpio_pkg::pin_tx] = async_serial_unit.data;
      pad.out_en_n[gpio_pkg::pin_tx] = !async_serial_unit.force_out ||
        (state.open_drain_control[gpio_pkg::od_async_serial]
         && async_serial_unit.data);
    end
  end

  // pins two..seven carry no analogue path; only pin one has the flag
  assign pin_out = pad.out;
  assign pin_oe_n = pad.out_en_n;

  // capture inputs only meaningful with direction bit at input
  assign unit_one_capture = pin_level[gpio_pkg::pin_two]
    & state.third_port_direction[gpio_pkg::pin_two];
  assign unit_two_capture = pin_level[gpio_pkg::pin_one]
    & state.third_port_direction[gpio_pkg::pin_one]
    & unit_two_on_pin_one & !secondary_osc_enabled;

  // timer clock gated off while the oscillator runs
  assign secondary_clock_input = pin_level[gpio_pkg::pin_zero]
    & !secondary_osc_enabled;

endmodule // third_port

/* File: third_port_properties.sv */
// concurrent checks on the pin side of the third port block
`timescale 1ns/1ns
module third_port_checks (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pads
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic pin_one_analog,
  // peripheral claims
  input wire gpio_pkg::periph_drive_type enhanced_compare_unit_one,
  input wire gpio_pkg::periph_drive_type sync_serial_clock,
  input wire gpio_pkg::periph_drive_type sync_serial_data,
  input wire gpio_pkg::periph_drive_type async_serial_unit,
  // oscillator
  input wire logic secondary_osc_enabled,
  input wire logic secondary_clock_input
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // covers the two synchroniser stages plus a margin
  sequence pin_zero_steady;
    $stable(pin_in[0]) [*4];
  endsequence
  a_reset_all_input:
  assert property ($rose(presetn) && !(sync_serial_clock.active | sync_serial_data.active
    | async_serial_unit.active) |-> pin_oe_n == 8'hFF) else $error("pins not inputs");
  a_osc_gates_clock:
  assert property (secondary_osc_enabled |-> !secondary_clock_input) else $error("clock leak");
  a_osc_pin_analog:
  assert property (pin_one_analog == secondary_osc_enabled) else $error("analog flag");
  a_clock_follows_pin:
  assert property (pin_zero_steady ##0 !secondary_osc_enabled
    |-> secondary_clock_input == pin_in[0]) else $error("clock input lost");
  a_sck_forced_input:
  assert property (sync_serial_clock.active && !sync_serial_clock.force_out |-> pin_oe_n[3])
    else $error("sck not input");
  a_sdo_forced_low:
  assert property (sync_serial_data.active && sync_serial_data.force_out
    && !sync_serial_data.data |-> !pin_oe_n[5] && !pin_out[5]) else $error("sdo not low");
  a_tx_drive_level:
  assert property (async_serial_unit.active && async_serial_unit.force_out && !pin_oe_n[6]
    |-> pin_out[6] == async_serial_unit.data) else $error("tx level");
  a_compare_drives:
  assert property (enhanced_compare_unit_one.active && !pin_oe_n[2]
    |-> pin_out[2] == enhanced_compare_unit_one.data) else $error("compare level");
endmodule // third_port_checks

bind third_port third_port_checks i_checks (.*);

/* File: board_pins.sv */
// board side of the port pads
`timescale 1ns/1ns
module board_pins (
  // clock
  input wire logic pclk,
  // pad side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  output logic [7:0] pin_in,
  // board drivers
  input wire logic [7:0] ext_level,
  input wire logic [7:0] ext_drive
);
  // no pulls on the board: a floating pad must never read as a fixed level
  logic [7:0] wander = 8'h55;
  always @(posedge pclk) wander <= ~wander;
  assign pin_in = ~pin_oe_n & pin_out | pin_oe_n & (ext_drive & ext_level | ~ext_drive & wander);
endmodule // board_pins

/* File: test_port_c_gpio_with_overrides.sv */
// self-checking bench for the third port block
`timescale 1ns/1ns
module test_port_c_gpio_with_overrides;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr;
  logic second_compare_pin_select = 1;
  logic pwm_shutdown_one = 0;
  logic pwm_shutdown_two = 0;
  logic [7:0] pin_in, pin_out, pin_oe_n;
  logic [7:0] ext_level = '0;
  logic [7:0] ext_drive = '0;
  logic pin_one_analog, unit_one_capture, unit_two_capture;
  logic secondary_osc_enabled, secondary_clock_input;
  gpio_pkg::periph_drive_type enhanced_compare_unit_one = '0, enhanced_compare_unit_two = '0;
  gpio_pkg::periph_drive_type sync_serial_clock = '0, sync_serial_data = '0;
  gpio_pkg::periph_drive_type async_serial_unit = '0;
  int miscompares = 0, checks_done = 0, cyc = 0, seed = 32'h9C0D, lat, dir;
  logic [11:0] offs [5] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};
  logic [31:0] rst [5] = '{32'h000000FF, 32'h0, 32'h0, 32'h0, 32'h0};

  third_port i_dut (.*);
  board_pins i_board (.*);

  always #2 pclk = ~pclk;

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task io(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask

  task stop_test;
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      stop_test;
    end
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    chk("oe", pin_oe_n, 8'hFF);
    // reset values, last place unmapped
    foreach (offs[i]) begin
      io(0, offs[i], 32'h0);
      chk("reset", q, rst[i]);
    end
    for (int i = 0; i < 8; i++) begin
      lat = $random(seed) & 255;
      dir = i ? $random(seed) & 255 : 8'hCF;
      io(1, i[0] ? gpio_pkg::latch_off : gpio_pkg::data_off, lat);
      io(1, gpio_pkg::direction_off, dir);
      ext_drive <= dir;
      ext_level <= $random(seed);
      repeat (3) @(posedge pclk);
      #1 chk("oe", pin_oe_n, dir);
      chk("out", pin_out & ~dir, lat & ~dir);
      io(0, gpio_pkg::data_off, 32'h0);
      chk("pins", q, (lat & ~dir | ext_level & dir) & 255);
      io(0, gpio_pkg::latch_off, 32'h0);
      chk("latch", q, lat);
      io(0, gpio_pkg::direction_off, 32'h0);
      chk("dir", q, dir);
    end
    io(1, gpio_pkg::data_off, 8'hFF);
    io(1, gpio_pkg::direction_off, 8'hF1);
    sync_serial_clock <= 3'b100;
    sync_serial_data <= 3'b110;
    @(posedge pclk);
    #1 chk("sck", pin_oe_n[3], 1);
    chk("sdo", {pin_oe_n[5], pin_out[5]}, 0);
    for (int k = 0; k < 4; k++) begin
      io(1, gpio_pkg::open_drain_off, k[0] << gpio_pkg::od_async_serial);
      async_serial_unit <= {2'b11, k[1]};
      @(posedge pclk);
      #1 chk("tx_oe", pin_oe_n[6], k[0] & k[1]);
      if (!(k[0] & k[1])) chk("tx", pin_out[6], k[1]);
    end
    enhanced_compare_unit_one <= 3'b101;
    enhanced_compare_unit_two <= 3'b100;
    @(posedge pclk);
    pwm_shutdown_one <= 1;
    @(posedge pclk);
    #1 chk("ccp", {pin_oe_n[2:1], pin_out[2:1]}, 4'b0010);
    io(1, gpio_pkg::periph_ctrl_off, 2);
    #1 chk("release", pin_oe_n[2], 1);
    io(1, gpio_pkg::direction_off, 8'hF5);
    ext_drive <= 8'h05;
    ext_level <= 8'h05;
    repeat (3) @(posedge pclk);
    #1 chk("cap", unit_one_capture, 1);
    chk("sclk", secondary_clock_input, 1);
    io(1, gpio_pkg::periph_ctrl_off, 1);
    #1 chk("osc", {pin_one_analog, secondary_osc_enabled, secondary_clock_input}, 3'b110);
    // mid-run reset with the strap low: unit two must lose pin one
    second_compare_pin_select <= 0;
    enhanced_compare_unit_two <= 3'b101;
    sync_serial_clock <= '0;
    sync_serial_data <= '0;
    async_serial_unit <= '0;
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    #1 chk("oe_rst", pin_oe_n, 8'hFF);
    io(1, gpio_pkg::direction_off, 8'hF9);
    #1 chk("unmapped", {pin_oe_n[1], pin_out[1]}, 2'b00);
    chk("ccp1", {pin_oe_n[2], pin_out[2]}, 2'b01);
    stop_test;
  end
endmodule // test_port_c_gpio_with_overrides
